// ### rtl/output_electronic_fuse.sv
// Staged electronic fuse and switching control for the low power channels.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
module output_electronic_fuse
  import fuse_pkg::*;
(
  input  logic                 mclk,
  input  logic                 rst,
  input  logic [AW-1:0]        addr,
  input  logic [31:0]          wdata,
  input  logic                 wr_stb,
  input  logic                 rd_stb,
  output logic [31:0]          rdata,
  input  logic [NCH-1:0]       evt_on,
  input  logic [2*NTRI-1:0]    evt_tri,
  input  logic [NCH*CUR_W-1:0] cur_ma,
  input  logic                 cur_valid,
  output logic [NCH-1:0]       ch_on,
  output logic [2*NTRI-1:0]    tri_lvl,
  output logic                 irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic chan_hit(input logic [AW-1:0] a);
    chan_hit = a[CH_BIT] && (int'(a[CH_BIT-1:FLD_W]) < NCH);
  endfunction

  function automatic logic [CUR_W-1:0] cont_limit(input logic [LIM_W-1:0] s);
    cont_limit = CUR_W'(CONT_BASE_MA + CONT_STEP_MA * int'(s));
  endfunction

  function automatic int clampv(input int v, input int lo, input int hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic us_tick;
  logic ms_tick;

  time_base u_tb (
    .mclk    (mclk),
    .rst     (rst),
    .us_tick (us_tick),
    .ms_tick (ms_tick)
  );

  logic [CH_BIT-FLD_W-1:0] ch_idx;
  logic [FLD_W-1:0]        fld;
  assign ch_idx = addr[CH_BIT-1:FLD_W];
  assign fld    = addr[FLD_W-1:0];

  // ----------------------------------------------------------------------
  // Per-channel settings
  // ----------------------------------------------------------------------
  logic [LIM_W-1:0]   lim_q   [NCH];
  logic [LIM_W-1:0]   lim_d   [NCH];
  logic [WIN_W-1:0]   win_q   [NCH];
  logic [WIN_W-1:0]   win_d   [NCH];
  logic [INIT_W-1:0]  init_q  [NCH];
  logic [INIT_W-1:0]  init_d  [NCH];
  logic [STD_W-1:0]   std_q   [NCH];
  logic [STD_W-1:0]   std_d   [NCH];
  logic [GRACE_W-1:0] grace_q [NCH];
  logic [GRACE_W-1:0] grace_d [NCH];
  logic [RET_W-1:0]   rmax_q  [NCH];
  logic [RET_W-1:0]   rmax_d  [NCH];
  logic [RINT_W-1:0]  rint_q  [NCH];
  logic [RINT_W-1:0]  rint_d  [NCH];

  // Writes are cut to the field width, then window, init, steady and grace are clamped so a channel can never run unprotected.
  always_comb begin
    lim_d   = lim_q;
    win_d   = win_q;
    init_d  = init_q;
    std_d   = std_q;
    grace_d = grace_q;
    rmax_d  = rmax_q;
    rint_d  = rint_q;
    if (wr_stb && chan_hit(addr)) begin
      case (fld)
        F_LIM:   lim_d[ch_idx] = wdata[LIM_W-1:0];
        F_WIN:   win_d[ch_idx] = WIN_W'(clampv(int'(wdata[WIN_W-1:0]),
                                  WIN_MIN_US, WIN_MAX_US));
        F_INIT:  init_d[ch_idx] = INIT_W'(clampv(int'(wdata[INIT_W-1:0]),
                                  0, INIT_MAX_MS));
        F_STD:   std_d[ch_idx] = STD_W'(clampv(int'(wdata[STD_W-1:0]),
                                  0, STD_MAX_MA));
        F_GRACE: grace_d[ch_idx] = GRACE_W'(clampv(int'(wdata[GRACE_W-1:0]),
                                  GRACE_MIN_MS, GRACE_MAX_MS));
        F_RMAX:  rmax_d[ch_idx] = wdata[RET_W-1:0];
        F_RINT:  rint_d[ch_idx] = wdata[RINT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k < NCH; k++) begin
        lim_q[k]   <= LIM_RST;
        win_q[k]   <= WIN_RST;
        init_q[k]  <= INIT_RST;
        std_q[k]   <= STD_RST;
        grace_q[k] <= GRACE_RST;
        rmax_q[k]  <= RMAX_RST;
        rint_q[k]  <= RINT_RST;
      end
    end else begin
      lim_q   <= lim_d;
      win_q   <= win_d;
      init_q  <= init_d;
      std_q   <= std_d;
      grace_q <= grace_d;
      rmax_q  <= rmax_d;
      rint_q  <= rint_d;
    end
  end

  // ----------------------------------------------------------------------
  // Current report
  // ----------------------------------------------------------------------
  logic [CUR_W-1:0] rep_q [NCH];
  logic [CUR_W-1:0] rep_d [NCH];
  logic [CUR_W-1:0] rep_v;

  always_comb begin
    rep_d = rep_q;
    rep_v = '0;
    if (cur_valid) begin
      for (int k = 0; k < NCH; k++) begin
        rep_v = cur_ma[k*CUR_W +: CUR_W];
        if (k < LORES_CH && rep_v < CUR_W'(LORES_MIN_MA)) begin
          rep_v = '0;
        end
        rep_d[k] = rep_v;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k < NCH; k++) begin
        rep_q[k] <= '0;
      end
    end else begin
      rep_q <= rep_d;
    end
  end

  // ----------------------------------------------------------------------
  // Global control, interrupt and tri-state outputs
  // ----------------------------------------------------------------------
  logic                ctrl_q, ctrl_d;
  logic [NCH-1:0]      man_q, man_d;
  logic [NCH-1:0]      stat_q, stat_d;
  logic [NCH-1:0]      mask_q, mask_d;
  logic [2*NTRI-1:0]   tri_q, tri_d;
  logic [NCH-1:0]      req;
  logic [NCH-1:0]      on_v;
  logic [NCH-1:0]      trip_v;
  logic [NCH-1:0]      lat_v;
  fuse_st_t            st_arr [NCH];

  // Manual requests replace the event requests entirely while manual is set.
  assign req = ctrl_q ? man_q : evt_on;

  always_comb begin
    ctrl_d = ctrl_q;
    man_d  = man_q;
    mask_d = mask_q;
    tri_d  = '0;
    if (wr_stb && addr == A_CTRL) begin
      ctrl_d = wdata[0];
      if (wdata[0] && !ctrl_q) begin
        man_d = '0;
      end
    end
    if (wr_stb && addr == A_MAN && ctrl_q) begin
      man_d = man_q ^ wdata[NCH-1:0];
    end
    if (wr_stb && addr == A_MASK) begin
      mask_d = wdata[NCH-1:0];
    end
    // A trip in the cycle of the clearing read still sets its bit.
    stat_d = ((rd_stb && addr == A_STAT) ? '0 : stat_q) | trip_v;
    for (int t = 0; t < NTRI; t++) begin
      if (!ctrl_q && evt_tri[2*t +: 2] != TRI_BAD) begin
        tri_d[2*t +: 2] = evt_tri[2*t +: 2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= 1'b0;
      man_q  <= '0;
      stat_q <= '0;
      mask_q <= '0;
      tri_q  <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      man_q  <= man_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      tri_q  <= tri_d;
    end
  end

  assign irq     = |(stat_q & mask_q);
  assign tri_lvl = tri_q;
  assign ch_on   = on_v;

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  logic [31:0] rd_q, rd_d;

  always_comb begin
    rd_d = '0;
    if (rd_stb && chan_hit(addr)) begin
      case (fld)
        F_LIM:   rd_d = 32'(lim_q[ch_idx]);
        F_WIN:   rd_d = 32'(win_q[ch_idx]);
        F_INIT:  rd_d = 32'(init_q[ch_idx]);
        F_STD:   rd_d = 32'(std_q[ch_idx]);
        F_GRACE: rd_d = 32'(grace_q[ch_idx]);
        F_RMAX:  rd_d = 32'(rmax_q[ch_idx]);
        F_RINT:  rd_d = 32'(rint_q[ch_idx]);
        F_CUR:   rd_d = 32'(rep_q[ch_idx]);
        F_ST:    rd_d = 32'(st_arr[ch_idx]);
        default: rd_d = '0;
      endcase
    end else if (rd_stb) begin
      case (addr)
        A_CTRL:  rd_d = 32'(ctrl_q);
        A_MAN:   rd_d = 32'(man_q);
        A_STAT:  rd_d = 32'(stat_q);
        A_MASK:  rd_d = 32'(mask_q);
        A_ON:    rd_d = 32'(on_v);
        A_LATCH: rd_d = 32'(lat_v);
        A_TRI:   rd_d = 32'(tri_q);
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rdata = rd_q;

  // ----------------------------------------------------------------------
  // Channel fuse sequencers
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    fuse_st_t           st_q, st_d;
    logic [WIN_W-1:0]   us_q, us_d;
    logic [MS_W-1:0]    ms_q, ms_d;
    logic [GRACE_W-1:0] gr_q, gr_d;
    logic [RET_W-1:0]   rt_q, rt_d;
    logic               on_q, on_d;
    logic [CUR_W-1:0]   cur;
    logic [CUR_W-1:0]   lim;
    logic               over, steady, hi_t, cl_t, sw_t, trip;

    assign cur    = cur_ma[i*CUR_W +: CUR_W];
    assign lim    = cont_limit(lim_q[i]);
    assign over   = cur > CUR_W'(std_q[i]);
    assign steady = ms_q >= MS_W'(init_q[i]);
    assign hi_t   = cur_valid && cur > CUR_W'(HIGH_MA);
    assign cl_t   = cur_valid && us_q >= win_q[i] && cur >= lim;
    assign sw_t   = cur_valid && steady && over && gr_q >= grace_q[i];
    // Checked on every sample; the switch opens on the next edge.
    assign trip   = st_q == ST_RUN && req[i] && (hi_t || cl_t || sw_t);

    always_comb begin
      st_d = st_q;
      us_d = (us_tick && !(&us_q)) ? us_q + 1'b1 : us_q;
      ms_d = (ms_tick && !(&ms_q)) ? ms_q + 1'b1 : ms_q;
      rt_d = rt_q;
      if (st_q != ST_RUN || !steady || (cur_valid && !over)) begin
        gr_d = '0;
      end else if (ms_tick && !(&gr_q)) begin
        gr_d = gr_q + 1'b1;
      end else begin
        gr_d = gr_q;
      end
      case (st_q)
        ST_OFF: begin
          if (req[i]) begin
            st_d = ST_BLANK;
            us_d = '0;
            ms_d = '0;
            rt_d = '0;
          end
        end
        ST_BLANK: begin
          if (!req[i]) begin
            st_d = ST_OFF;
          end else if (us_q > WIN_W'(BLANK_US)) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!req[i]) begin
            st_d = ST_OFF;
          end else if (trip && rt_q < rmax_q[i]) begin
            st_d = ST_WAIT;
            ms_d = '0;
          end else if (trip) begin
            st_d = ST_LATCH;
          end
        end
        ST_WAIT: begin
          if (!req[i]) begin
            st_d = ST_OFF;
          end else if (ms_q >= MS_W'(rint_q[i])) begin
            st_d = ST_BLANK;
            us_d = '0;
            ms_d = '0;
            rt_d = rt_q + 1'b1;
          end
        end
        ST_LATCH: begin
          if (!req[i]) begin
            st_d = ST_OFF;
          end
        end
        default: st_d = ST_OFF;
      endcase
      on_d = st_d == ST_BLANK || st_d == ST_RUN;
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        st_q <= ST_OFF;
        us_q <= '0;
        ms_q <= '0;
        gr_q <= '0;
        rt_q <= '0;
        on_q <= 1'b0;
      end else begin
        st_q <= st_d;
        us_q <= us_d;
        ms_q <= ms_d;
        gr_q <= gr_d;
        rt_q <= rt_d;
        on_q <= on_d;
      end
    end

    assign on_v[i]   = on_q;
    assign trip_v[i] = trip;
    assign lat_v[i]  = st_q == ST_LATCH;
    assign st_arr[i] = st_q;

    property p_inrush;
      (st_q == ST_BLANK && req[i] && cur_valid) |=> on_q;
    endproperty
    a_inrush: assert property (p_inrush)
      else $error("channel opened during inrush blanking");

    property p_high;
      (st_q == ST_RUN && req[i] && cur_valid && cur > CUR_W'(HIGH_MA))
        |=> (!on_q && (st_q == ST_WAIT || st_q == ST_LATCH));
    endproperty
    a_high: assert property (p_high)
      else $error("high limit exceeded without trip");

    property p_cont;
      (st_q == ST_RUN && req[i] && cur_valid && us_q >= win_q[i]
        && cur >= cont_limit(lim_q[i])) |=> !on_q;
    endproperty
    a_cont: assert property (p_cont)
      else $error("continuous limit exceeded after window without trip");

    property p_steady;
      (st_q == ST_RUN && req[i] && cur_valid && ms_q >= MS_W'(init_q[i])
        && cur > CUR_W'(std_q[i]) && gr_q >= grace_q[i]) |=> !on_q;
    endproperty
    a_steady: assert property (p_steady)
      else $error("steady fuse level exceeded past grace without trip");

    property p_grace;
      (st_q == ST_RUN && req[i] && cur < cont_limit(lim_q[i])
        && gr_q < grace_q[i]) |=> on_q;
    endproperty
    a_grace: assert property (p_grace)
      else $error("channel opened inside grace time");

    property p_retry;
      (trip && rt_q < rmax_q[i]) |=> (st_q == ST_WAIT && !on_q && $stable(rt_q));
    endproperty
    a_retry: assert property (p_retry)
      else $error("trip with retries left did not wait for re-activation");

    property p_wait;
      (st_q == ST_WAIT && req[i] && ms_q < MS_W'(rint_q[i])) |=> st_q == ST_WAIT;
    endproperty
    a_wait: assert property (p_wait)
      else $error("re-activation before interval elapsed");

    property p_latch;
      (st_q == ST_LATCH && req[i]) |=> (st_q == ST_LATCH && !on_q);
    endproperty
    a_latch: assert property (p_latch)
      else $error("latched channel left off state with request held");

    property p_fresh;
      (st_q == ST_OFF && req[i]) |=> (rt_q == '0 && on_q);
    endproperty
    a_fresh: assert property (p_fresh)
      else $error("fresh request did not restart channel");

    property p_lores;
      (cur_valid && i < LORES_CH && cur < CUR_W'(LORES_MIN_MA)) |=> rep_q[i] == '0;
    endproperty
    a_lores: assert property (p_lores)
      else $error("low current reported on low resolution channel");
  end

  // ----------------------------------------------------------------------
  // Module level checks
  // ----------------------------------------------------------------------
  property p_manual;
    (wr_stb && addr == A_CTRL && wdata[0] && !ctrl_q)
      |=> (ctrl_q && man_q == '0) ##1 (ch_on == '0);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual entry did not force all channels off");

  property p_tri;
    (tri_lvl & (tri_lvl >> 1) & TRI_ODD) == '0;
  endproperty
  a_tri: assert property (p_tri)
    else $error("tri-state output on illegal level");

  property p_stat;
    (|trip_v) |=> ((stat_q & $past(trip_v)) == $past(trip_v));
  endproperty
  a_stat: assert property (p_stat)
    else $error("trip event lost from status");

  c_retry:  cover property (g_ch[0].st_q == ST_WAIT ##1 g_ch[0].st_q == ST_BLANK);
  c_latch:  cover property (g_ch[0].st_q == ST_RUN ##1 g_ch[0].st_q == ST_LATCH);
  c_manual: cover property (ctrl_q && wr_stb && addr == A_MAN);
endmodule

// ### rtl/fuse_pkg.sv
// Constants, register map and types shared by the output electronic fuse.
// -------------------------------------------------------------------------
package fuse_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NCH     = 26;
  localparam int NTRI    = 4;
  localparam int AW      = 10;
  localparam int CH_BIT  = 9;
  localparam int FLD_W   = 4;
  localparam int CUR_W   = 17;
  localparam int LIM_W   = 3;
  localparam int WIN_W   = 18;
  localparam int INIT_W  = 14;
  localparam int STD_W   = 15;
  localparam int GRACE_W = 8;
  localparam int RET_W   = 4;
  localparam int RINT_W  = 16;
  localparam int MS_W    = 16;
  // ----------------------------------------------------------------------
  // Timing and thresholds
  // ----------------------------------------------------------------------
  localparam int CLK_HZ       = 25_000_000;
  localparam int US_CYC       = CLK_HZ / 1_000_000;
  localparam int US_PER_MS    = 1000;
  localparam int BLANK_US     = 20;
  localparam int HIGH_MA      = 75_000;
  localparam int CONT_BASE_MA = 7_500;
  localparam int CONT_STEP_MA = 2_500;
  localparam int WIN_MIN_US   = 150;
  localparam int WIN_MAX_US   = 155_000;
  localparam int INIT_MAX_MS  = 10_000;
  localparam int STD_MAX_MA   = 25_000;
  localparam int GRACE_MIN_MS = 25;
  localparam int GRACE_MAX_MS = 250;
  localparam int LORES_CH     = 22;
  localparam int LORES_MIN_MA = 200;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [LIM_W-1:0]   LIM_RST   = 3'h0;
  localparam logic [WIN_W-1:0]   WIN_RST   = 18'h25d78;
  localparam logic [INIT_W-1:0]  INIT_RST  = 14'h00c8;
  localparam logic [STD_W-1:0]   STD_RST   = 15'h0fa0;
  localparam logic [GRACE_W-1:0] GRACE_RST = 8'h19;
  localparam logic [RET_W-1:0]   RMAX_RST  = 4'h3;
  localparam logic [RINT_W-1:0]  RINT_RST  = 16'h00fa;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0]    A_CTRL  = 10'h000;
  localparam logic [AW-1:0]    A_MAN   = 10'h001;
  localparam logic [AW-1:0]    A_STAT  = 10'h002;
  localparam logic [AW-1:0]    A_MASK  = 10'h003;
  localparam logic [AW-1:0]    A_ON    = 10'h004;
  localparam logic [AW-1:0]    A_LATCH = 10'h005;
  localparam logic [AW-1:0]    A_TRI   = 10'h006;
  localparam logic [FLD_W-1:0] F_LIM   = 4'h0;
  localparam logic [FLD_W-1:0] F_WIN   = 4'h1;
  localparam logic [FLD_W-1:0] F_INIT  = 4'h2;
  localparam logic [FLD_W-1:0] F_STD   = 4'h3;
  localparam logic [FLD_W-1:0] F_GRACE = 4'h4;
  localparam logic [FLD_W-1:0] F_RMAX  = 4'h5;
  localparam logic [FLD_W-1:0] F_RINT  = 4'h6;
  localparam logic [FLD_W-1:0] F_CUR   = 4'h7;
  localparam logic [FLD_W-1:0] F_ST    = 4'h8;
  localparam logic [1:0]       TRI_0V  = 2'h0;
  localparam logic [1:0]       TRI_BAD = 2'h3;
  localparam logic [7:0]       TRI_ODD = 8'h55;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_BLANK = 3'b001,
    ST_RUN   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_LATCH = 3'b100
  } fuse_st_t;
endpackage

// ### rtl/time_base.sv
// Microsecond and millisecond tick generator for the fuse timers.
`timescale 1ns/1ns
module time_base
  import fuse_pkg::*;
#(
  parameter int US_CYC_P = US_CYC,
  parameter int MS_US_P  = US_PER_MS
)(
  input  logic mclk,
  input  logic rst,
  output logic us_tick,
  output logic ms_tick
);
  localparam int CW = $clog2(US_CYC_P);
  localparam int UW = $clog2(MS_US_P);

  logic [CW-1:0] cyc_q, cyc_d;
  logic [UW-1:0] us_q, us_d;
  logic          ust_q, ust_d;
  logic          mst_q, mst_d;

  always_comb begin
    cyc_d = cyc_q + 1'b1;
    us_d  = us_q;
    ust_d = 1'b0;
    mst_d = 1'b0;
    if (cyc_q == CW'(US_CYC_P - 1)) begin
      cyc_d = '0;
      ust_d = 1'b1;
      us_d  = us_q + 1'b1;
      if (us_q == UW'(MS_US_P - 1)) begin
        us_d  = '0;
        mst_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cyc_q <= '0;
      us_q  <= '0;
      ust_q <= 1'b0;
      mst_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      us_q  <= us_d;
      ust_q <= ust_d;
      mst_q <= mst_d;
    end
  end

  assign us_tick = ust_q;
  assign ms_tick = mst_q;
endmodule

// ### testbench/load_model.sv
// Switched load model standing behind the current sense stages of the channels.
`timescale 1ns/1ns
module load_model
  import fuse_pkg::*;
(
  input  logic                 mclk,
  input  logic                 rst,
  input  logic [NCH-1:0]       ch_on,
  input  logic [NCH*CUR_W-1:0] load_ma,
  output logic [NCH*CUR_W-1:0] cur_ma,
  output logic                 cur_valid
);
  logic [4:0] div_q;
  // An open switch carries no current, so its sense stage reads zero, not the old value.
  always_ff @(posedge mclk) begin
    div_q     <= (rst || div_q == 5'h18) ? 5'h00 : div_q + 5'h01;
    cur_valid <= !rst && div_q == 5'h18;
    for (int k = 0; k < NCH; k++) begin
      cur_ma[k*CUR_W +: CUR_W] <= ch_on[k] ? load_ma[k*CUR_W +: CUR_W] : '0;
    end
  end
endmodule

// ### testbench/output_electronic_fuse_tb_top.sv
// Register level testbench for the output electronic fuse.
`timescale 1ns/1ns
module output_electronic_fuse_tb_top
  import fuse_pkg::*;
;
  logic                 mclk, rst, wr_stb, rd_stb, cur_valid, irq;
  logic [AW-1:0]        addr;
  logic [31:0]          wdata, rdata;
  logic [NCH-1:0]       evt_on, ch_on;
  logic [2*NTRI-1:0]    evt_tri, tri_lvl;
  logic [NCH*CUR_W-1:0] cur_ma, load_ma;
  int                   errors, n_checks;

  output_electronic_fuse output_electronic_fuse_i (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .evt_on(evt_on),
    .evt_tri(evt_tri), .cur_ma(cur_ma), .cur_valid(cur_valid), .ch_on(ch_on),
    .tri_lvl(tri_lvl), .irq(irq));
  load_model load_model_i (.mclk(mclk), .rst(rst), .ch_on(ch_on), .load_ma(load_ma),
    .cur_ma(cur_ma), .cur_valid(cur_valid));

  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  function automatic logic [AW-1:0] ca(input logic [4:0] c, input logic [FLD_W-1:0] f);
    return {1'b1, c, f};
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A gap cycle after each write keeps the strobe from being driven twice at one edge.
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rc(input logic [AW-1:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    // Read data stand only in the cycle after the strobe, so they are taken at its closing edge.
    @(posedge mclk);
    chk($sformatf("rdata at %h", a), e, rdata);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #3_600_000;
    errors++;
    finish_test;
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {mclk, wr_stb, rd_stb, addr, wdata, evt_on, evt_tri, load_ma} = '0;
    rst = 1'b1;
    errors = 0;
    n_checks = 0;
    w(2);
    rst <= 1'b0;
    chk("ch_on", 32'h0, {6'h0, ch_on});
    rc(ca(0, F_WIN), 32'd155000);
    rc(ca(0, F_INIT), 32'd200);
    rc(ca(0, F_STD), 32'd4000);
    wr(ca(5, F_STD), 32'd30000);
    rc(ca(5, F_STD), 32'd25000);
    wr(ca(5, F_GRACE), 32'd255);
    rc(ca(5, F_GRACE), 32'd250);
    wr(ca(5, F_GRACE), 32'd10);
    rc(ca(5, F_GRACE), 32'd25);
    // Inrush far above the high limit: tolerated in blanking, tripped after it.
    wr(A_MASK, 32'h1);
    wr(ca(0, F_RMAX), 32'h1);
    wr(ca(0, F_RINT), 32'h2);
    load_ma[16:0] <= 17'd80000;
    evt_on[0] <= 1'b1;
    w(250);
    chk("ch_on0 blank", 32'h1, {31'h0, ch_on[0]});
    w(750);
    chk("ch_on0 high", 32'h0, {31'h0, ch_on[0]});
    chk("irq", 32'h1, {31'h0, irq});
    rc(A_STAT, 32'h1);
    chk("irq clr", 32'h0, {31'h0, irq});
    rc(ca(0, F_ST), 32'h3);
    w(12500);
    rc(ca(0, F_ST), 32'h3);
    w(50000);
    rc(ca(0, F_ST), 32'h4);
    rc(A_LATCH, 32'h1);
    evt_on[0] <= 1'b0;
    load_ma[16:0] <= '0;
    w(4);
    rc(ca(0, F_ST), 32'h0);
    evt_on[0] <= 1'b1;
    w(4);
    chk("ch_on0 fresh", 32'h1, {31'h0, ch_on[0]});
    evt_on[0] <= 1'b0;
    // Current above the continuous limit past a 150 us window.
    wr(ca(1, F_WIN), 32'd150);
    load_ma[33:17] <= 17'd8000;
    evt_on[1] <= 1'b1;
    w(2500);
    chk("ch_on1 win", 32'h1, {31'h0, ch_on[1]});
    w(1875);
    chk("ch_on1 cont", 32'h0, {31'h0, ch_on[1]});
    evt_on[1] <= 1'b0;
    // Let the dropped request reach the channel before the pairs are commanded.
    w(2);
    // Both halves of two pairs are commanded in the same cycle.
    for (int k = 0; k < NCH; k++) load_ma[k*CUR_W +: CUR_W] <= 17'd100;
    evt_on <= 26'h0c00003;
    w(100);
    rc(A_ON, 32'h0c00003);
    rc(ca(0, F_CUR), 32'h0);
    rc(ca(22, F_CUR), 32'd100);
    rc(ca(26, F_CUR), 32'h0);
    rc(10'h0ff, 32'h0);
    for (int c = 0; c < 4; c++) begin
      evt_tri <= {4{c[1:0]}};
      w(3);
      chk("tri_lvl", (c == 3) ? 32'h0 : {24'h0, {4{c[1:0]}}}, {24'h0, tri_lvl});
      rc(A_TRI, (c == 3) ? 32'h0 : {24'h0, {4{c[1:0]}}});
    end
    // Manual mode overrides the event requests that are still high.
    wr(A_CTRL, 32'h1);
    w(3);
    chk("ch_on man", 32'h0, {6'h0, ch_on});
    wr(A_MAN, 32'h4);
    w(3);
    chk("ch_on tog", 32'h4, {6'h0, ch_on});
    wr(A_MAN, 32'h4);
    w(3);
    chk("ch_on tog", 32'h0, {6'h0, ch_on});
    finish_test;
  end
endmodule
